// File: rtl/srw_supervisor.sv
// supervisor top: reset pulse, watchdog and power-fail flag
`timescale 1ns/1ps
module srw_supervisor #(
  parameter logic [15:0] TICK_CYCLES = srw_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic supply_low_in,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_hiz_in,
  input wire logic power_fail_sense_in,
  output logic reset_out_n,
  output logic reset_out,
  output logic watchdog_expired_n,
  output logic power_fail_flag_n
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  srw_pin_if p ();

  // three flops and agreement; 50 ns pulses span two samples
  srw_pin_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .supply_low_in(supply_low_in),
    .manual_reset_n(manual_reset_n),
    .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_hiz_in(watchdog_kick_hiz_in),
    .power_fail_sense_in(power_fail_sense_in),
    .pins(p.sync)
  );

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [15:0] div_count;       // free-running divider
  logic [15:0] next_div_count;  // next divider value
  logic tick;                   // one-cycle pulse per ms

  // divider wraps every TICK_CYCLES cycles
  always_comb begin
    tick = (div_count == TICK_CYCLES - 16'h0001);
    if (tick) begin
      next_div_count = 16'h0000;
    end else begin
      next_div_count = div_count + 16'h0001;
    end
  end

  // register the divider
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_count <= 16'h0000;
    end else begin
      div_count <= next_div_count;
    end
  end

  // ----------------------------------------------------------------
  // reset pulse sequencer
  // ----------------------------------------------------------------
  srw_pkg::srw_rst_state_t state;       // pulse or running
  srw_pkg::srw_rst_state_t next_state;  // next state
  logic [10:0] rst_count;               // ticks since trigger ended
  logic [10:0] next_rst_count;          // next tick count
  logic trigger;                        // a reset cause is present
  logic next_reset_out_n;               // next active-low reset

  // hold while a cause is present, then time the hold-off
  always_comb begin
    trigger = p.supply_low | ~p.manual_reset_n;
    next_state = state;
    next_rst_count = rst_count;
    if (trigger) begin
      // any cause restarts the full hold-off
      next_state = srw_pkg::SRW_RST_PULSE;
      next_rst_count = 11'h000;
    end else begin
      case (state)
        srw_pkg::SRW_RST_PULSE: begin
          // count ms ticks until the pulse is complete
          if (tick) begin
            next_rst_count = rst_count + 11'h001;
            if (rst_count == srw_pkg::RESET_LAST) begin
              next_state = srw_pkg::SRW_RST_RUN;
            end
          end
        end
        srw_pkg::SRW_RST_RUN: begin
          // released; only a new cause restarts the pulse
          next_rst_count = rst_count;
        end
        default: begin
          next_state = srw_pkg::SRW_RST_PULSE;
          next_rst_count = 11'h000;
        end
      endcase
    end
    // both outputs are driven from the same next state
    next_reset_out_n = (next_state == srw_pkg::SRW_RST_RUN);
  end

  // register sequencer and both reset outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= srw_pkg::SRW_RST_PULSE;
      rst_count <= 11'h000;
      reset_out_n <= 1'b0;
      reset_out <= 1'b1;
    end else begin
      state <= next_state;
      rst_count <= next_rst_count;
      reset_out_n <= next_reset_out_n;
      reset_out <= ~next_reset_out_n;
    end
  end

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  logic [10:0] wd_count;        // ticks since last clear
  logic [10:0] next_wd_count;   // next watchdog count
  logic kick_prev;              // kick level one cycle back
  logic kick_edge;              // kick changed level
  logic wd_clear;               // any clearing condition
  logic next_watchdog_n;        // next watchdog output
  logic next_power_flag_n;      // next power-fail flag

  // clear on reset, float or edge; count ms otherwise
  always_comb begin
    kick_edge = p.kick ^ kick_prev;
    wd_clear = (state != srw_pkg::SRW_RST_RUN) | p.kick_hiz | kick_edge;
    if (wd_clear) begin
      next_wd_count = 11'h000;
    end else if (tick && (wd_count != srw_pkg::WD_TICKS)) begin
      next_wd_count = wd_count + 11'h001;
    end else begin
      // saturate once expired so the output stays low
      next_wd_count = wd_count;
    end
    // low on expiry or low supply; no hold-off on release
    next_watchdog_n = ~((next_wd_count == srw_pkg::WD_TICKS) |
                        p.supply_low);
    next_power_flag_n = p.power_ok;
  end

  // register watchdog state and flag outputs
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wd_count <= 11'h000;
      kick_prev <= 1'b0;
      watchdog_expired_n <= 1'b0;
      power_fail_flag_n <= 1'b1;
    end else begin
      wd_count <= next_wd_count;
      kick_prev <= p.kick;
      watchdog_expired_n <= next_watchdog_n;
      power_fail_flag_n <= next_power_flag_n;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [10:0] pulse_ticks;  // ticks seen since last cause ended

  // independent tally of the hold-off for the width check
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_ticks <= 11'h000;
    end else if (trigger) begin
      pulse_ticks <= 11'h000;
    end else if (tick && (pulse_ticks != 11'h7FF)) begin
      pulse_ticks <= pulse_ticks + 11'h001;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  reset_hold_a: assert property (
    trigger |=> !reset_out_n ##0 reset_out)
    else $error("reset not held while a cause is present");

  pulse_width_a: assert property (
    $rose(reset_out_n) |-> pulse_ticks == srw_pkg::RESET_TICKS)
    else $error("reset released at wrong hold-off");

  no_early_release_a: assert property (
    (!trigger && !reset_out_n && pulse_ticks < srw_pkg::RESET_LAST)
    |=> !reset_out_n)
    else $error("reset released before hold-off ended");

  wd_no_reset_a: assert property (
    (state == srw_pkg::SRW_RST_RUN && !trigger) |=> reset_out_n)
    else $error("reset asserted without a cause");

  reset_pair_a: assert property (
    reset_out == !reset_out_n)
    else $error("reset outputs not complementary");

  wd_expire_a: assert property (
    (wd_count == srw_pkg::WD_LAST && tick && !wd_clear)
    |=> !watchdog_expired_n [*2])
    else $error("watchdog did not expire on time");

  wd_float_clear_a: assert property (
    p.kick_hiz |=> wd_count == 11'h000 ##0
      (watchdog_expired_n == !$past(p.supply_low)))
    else $error("floating kick did not disable watchdog");

  wd_reset_clear_a: assert property (
    !reset_out_n |=> wd_count == 11'h000)
    else $error("watchdog counted during reset");

  wd_kick_clear_a: assert property (
    (p.kick != $past(p.kick)) |=> wd_count == 11'h000)
    else $error("kick edge did not clear watchdog");

  wd_hold_low_a: assert property (
    (wd_count == srw_pkg::WD_TICKS && !wd_clear) |=> !watchdog_expired_n)
    else $error("watchdog output released without clear");

  wd_lowline_a: assert property (
    p.supply_low |=> !watchdog_expired_n)
    else $error("watchdog output high during low supply");

  wd_recover_a: assert property (
    $fell(p.supply_low) |=> watchdog_expired_n)
    else $error("watchdog output delayed after recovery");

  pf_flag_a: assert property (
    ##1 power_fail_flag_n == $past(p.power_ok))
    else $error("power-fail flag does not follow sense");

  release_c: cover property ($rose(reset_out_n));
  expire_c: cover property ($fell(watchdog_expired_n) && !p.supply_low);
  kick_c: cover property (kick_edge && state == srw_pkg::SRW_RST_RUN);
  brownout_c: cover property (!reset_out_n && $rose(p.supply_low));

endmodule

// File: rtl/srw_pkg.sv
// shared constants and types for the supervisor and watchdog block
package srw_pkg;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;        // mclk period, 50 MHz
  localparam int TICK_PERIOD_NS = 1000000;  // one time base tick, 1 ms
  localparam int TICK_MS = 1;               // tick length in ms
  // cycles per time base tick
  localparam logic [15:0] TICK_CYCLES =
    16'(TICK_PERIOD_NS / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // durations
  // ----------------------------------------------------------------
  localparam int RESET_PULSE_MS = 200;      // reset hold-off
  localparam int WD_TIMEOUT_MS = 1600;      // watchdog timeout
  // tick counts, counters are 11 bits wide
  localparam logic [10:0] RESET_TICKS = 11'(RESET_PULSE_MS / TICK_MS);
  localparam logic [10:0] RESET_LAST =
    11'(RESET_PULSE_MS / TICK_MS - 1);
  localparam logic [10:0] WD_TICKS = 11'(WD_TIMEOUT_MS / TICK_MS);
  localparam logic [10:0] WD_LAST = 11'(WD_TIMEOUT_MS / TICK_MS - 1);

  // ----------------------------------------------------------------
  // pin synchroniser layout
  // ----------------------------------------------------------------
  localparam int PIN_SUPPLY_LOW = 4;        // undervoltage indication
  localparam int PIN_MANUAL_RESET_N = 3;    // manual reset, active low
  localparam int PIN_KICK = 2;              // watchdog kick level
  localparam int PIN_KICK_HIZ = 1;          // kick line floating
  localparam int PIN_POWER_OK = 0;          // sense above reference
  // value of filtered pins during reset: low supply, kick floating
  localparam logic [4:0] PIN_RESET_VALUE = 5'h1B;

  // reset output sequencer states
  typedef enum {
    SRW_RST_PULSE,
    SRW_RST_RUN
  } srw_rst_state_t;

endpackage

// File: rtl/srw_pin_if.sv
// filtered pin levels passed from the synchroniser to the core
`timescale 1ns/1ps
interface srw_pin_if;
  logic supply_low;      // supply below reset threshold
  logic manual_reset_n;  // manual reset, active low
  logic kick;            // watchdog kick level
  logic kick_hiz;        // kick line floating
  logic power_ok;        // sense input above reference

  // the synchroniser drives all filtered levels
  modport sync (
    output supply_low,
    output manual_reset_n,
    output kick,
    output kick_hiz,
    output power_ok
  );

  // the core only reads them
  modport core (
    input supply_low,
    input manual_reset_n,
    input kick,
    input kick_hiz,
    input power_ok
  );
endinterface

// File: rtl/srw_pin_sync.sv
// three-stage synchroniser with agreement filter for the input pins
`timescale 1ns/1ps
module srw_pin_sync (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic supply_low_in,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_hiz_in,
  input wire logic power_fail_sense_in,
  srw_pin_if.sync pins
);

  // ----------------------------------------------------------------
  // synchroniser stages
  // ----------------------------------------------------------------
  logic [4:0] raw;        // gathered pin levels
  logic [4:0] stage1;     // first flop, read only by stage2
  logic [4:0] stage2;     // second flop
  logic [4:0] stage3;     // third flop
  logic [4:0] filt;       // accepted level
  logic [4:0] next_filt;  // next accepted level

  assign raw = {supply_low_in, manual_reset_n, watchdog_kick_in,
                watchdog_kick_hiz_in, power_fail_sense_in};

  // a bit changes only once the second and third stages agree
  always_comb begin
    next_filt = (~(stage2 ^ stage3) & stage3) |
                ((stage2 ^ stage3) & filt);
  end

  // register all stages
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= srw_pkg::PIN_RESET_VALUE;
      stage2 <= srw_pkg::PIN_RESET_VALUE;
      stage3 <= srw_pkg::PIN_RESET_VALUE;
      filt <= srw_pkg::PIN_RESET_VALUE;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
      filt <= next_filt;
    end
  end

  // ----------------------------------------------------------------
  // hand filtered levels to the core
  // ----------------------------------------------------------------
  assign pins.supply_low = filt[srw_pkg::PIN_SUPPLY_LOW];
  assign pins.manual_reset_n = filt[srw_pkg::PIN_MANUAL_RESET_N];
  assign pins.kick = filt[srw_pkg::PIN_KICK];
  assign pins.kick_hiz = filt[srw_pkg::PIN_KICK_HIZ];
  assign pins.power_ok = filt[srw_pkg::PIN_POWER_OK];

endmodule

// File: verification/srw_cpu_model.sv
// behavioural processor that kicks the watchdog and obeys reset
`timescale 1ns/1ps
module srw_cpu_model #(
  parameter int KICK_GAP = 50
) (
  input wire logic mclk,
  input wire logic reset_out_n,
  input wire logic [1:0] mode,
  output logic watchdog_kick_in,
  output logic watchdog_kick_hiz_in
);
  // mode 0 holds, 1 toggles, 2 releases the line, 3 inverts briefly
  logic lvl;  // level the processor drives
  int cnt;    // cycles since the last toggle

  initial begin
    lvl = 1'b0;
    cnt = 0;
    watchdog_kick_in = 1'b0;
    watchdog_kick_hiz_in = 1'b1;
  end

  // ----------------------------------------------------------------
  // kick driver
  // ----------------------------------------------------------------
  // a processor held in reset runs no code, so it never toggles then
  always @(posedge mclk) begin
    watchdog_kick_hiz_in <= (mode == 2'h2);
    if (mode == 2'h2) begin
      // released line shows no stable level
      watchdog_kick_in <= ~watchdog_kick_in;
    end else if (mode == 2'h3) begin
      watchdog_kick_in <= ~lvl;
    end else begin
      watchdog_kick_in <= lvl;
    end
    if (mode == 2'h1 && reset_out_n === 1'b1) begin
      cnt <= (cnt == KICK_GAP) ? 0 : cnt + 1;
      // toggle well inside the timeout
      if (cnt == KICK_GAP) begin
        lvl <= ~lvl;
      end
    end
  end
endmodule

// File: verification/srw_supervisor_tb.sv
// self-checking bench for the supervisor and watchdog top
`timescale 1ns/1ps
module srw_supervisor_tb;
  localparam logic [15:0] TC = 16'h0004;  // short tick for simulation
  localparam int T = 4;                   // same tick as an int
  logic mclk, reset_n, supply_low_in, manual_reset_n;
  logic power_fail_sense_in, watchdog_kick_in, watchdog_kick_hiz_in;
  logic reset_out_n, reset_out, watchdog_expired_n, power_fail_flag_n;
  logic [1:0] mode;  // processor model behaviour
  int n_fail, checks;

  srw_supervisor #(.TICK_CYCLES(TC)) uut (
    .mclk(mclk), .reset_n(reset_n), .supply_low_in(supply_low_in),
    .manual_reset_n(manual_reset_n),
    .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_hiz_in(watchdog_kick_hiz_in),
    .power_fail_sense_in(power_fail_sense_in),
    .reset_out_n(reset_out_n), .reset_out(reset_out),
    .watchdog_expired_n(watchdog_expired_n),
    .power_fail_flag_n(power_fail_flag_n)
  );

  srw_cpu_model cpu (
    .mclk(mclk), .reset_out_n(reset_out_n), .mode(mode),
    .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_hiz_in(watchdog_kick_hiz_in)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // compare one seen bit with its expected value
  task automatic check(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // count falling edges until an output reaches a level, bounded
  task automatic wait_for(input int sel, input logic lvl, input int lim,
                          output int n);
    logic v;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
      v = (sel == 0) ? reset_out_n :
          (sel == 1) ? watchdog_expired_n : power_fail_flag_n;
    end while (v !== lvl && n < lim);
  endtask

  // reset release must land 199..200 ticks after its cause cleared
  task automatic check_release(input int n0);
    int n;
    wait_for(0, 1'b1, 1200, n);
    n = n + n0;
    check(logic'(n >= 199 * T + 2 && n <= 200 * T + 6), 1'b1, "pulse");
    check(reset_out, 1'b0, "complement high");
  endtask

  task finish_test;
    if (n_fail == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up;
    tick(5);
    check(reset_out_n, 1'b0, "reset during low supply");
    check(reset_out, 1'b1, "complement during low supply");
    check(watchdog_expired_n, 1'b0, "watchdog low supply");
    supply_low_in <= 1'b0;
    check_release(0);
  endtask

  task automatic t_manual;
    int n;
    @(posedge mclk);
    manual_reset_n <= 1'b0;
    wait_for(0, 1'b0, 6, n);
    check(reset_out_n, 1'b0, "manual reset start");
    check(reset_out, 1'b1, "manual reset complement");
    tick(1000);
    check(reset_out_n, 1'b0, "held while input low");
    manual_reset_n <= 1'b1;
    check_release(0);
  endtask

  task automatic t_brownout;
    int n;
    @(posedge mclk);
    manual_reset_n <= 1'b0;
    tick(4);
    manual_reset_n <= 1'b1;
    tick(300);
    supply_low_in <= 1'b1;
    wait_for(1, 1'b0, 6, n);
    check(watchdog_expired_n, 1'b0, "watchdog on low supply");
    tick(20);
    supply_low_in <= 1'b0;
    wait_for(1, 1'b1, 6, n);
    check(watchdog_expired_n, 1'b1, "watchdog on recovery");
    check(reset_out_n, 1'b0, "reset still held");
    check_release(n);
  endtask

  task automatic t_watchdog;
    int n;
    mode <= 2'h1;
    tick(2000 * T);
    check(watchdog_expired_n, 1'b1, "kicked watchdog");
    mode <= 2'h0;
    manual_reset_n <= 1'b0;
    tick(4);
    manual_reset_n <= 1'b1;
    // the pulse starts a few edges later; catch it before its release
    wait_for(0, 1'b0, 6, n);
    check(reset_out_n, 1'b0, "manual pulse before timeout");
    wait_for(0, 1'b1, 1200, n);
    // counter was cleared by reset and starts from its release
    wait_for(1, 1'b0, 7000, n);
    check(logic'(n >= 1599 * T - 1 && n <= 1600 * T + 3), 1'b1, "timeout");
    check(reset_out_n, 1'b1, "expiry leaves reset");
    tick(100);
    check(watchdog_expired_n, 1'b0, "expired stays low");
    mode <= 2'h3;
    tick(3);
    mode <= 2'h0;
    wait_for(1, 1'b1, 10, n);
    check(watchdog_expired_n, 1'b1, "short kick clears");
  endtask

  task automatic t_float;
    @(posedge mclk);
    mode <= 2'h2;
    tick(1700 * T);
    check(watchdog_expired_n, 1'b1, "floating kick");
    mode <= 2'h1;
  endtask

  task automatic t_power_fail;
    int n;
    @(posedge mclk);
    power_fail_sense_in <= 1'b0;
    wait_for(2, 1'b0, 6, n);
    check(power_fail_flag_n, 1'b0, "flag low");
    @(posedge mclk);
    power_fail_sense_in <= 1'b1;
    wait_for(2, 1'b1, 6, n);
    check(power_fail_flag_n, 1'b1, "flag high");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    checks = 0;
    reset_n = 1'b0;
    supply_low_in = 1'b1;
    manual_reset_n = 1'b1;
    power_fail_sense_in = 1'b1;
    mode = 2'h1;
    tick(10);
    reset_n <= 1'b1;
    t_power_up();
    t_manual();
    t_brownout();
    t_watchdog();
    t_float();
    t_power_fail();
    finish_test();
  end

  initial begin
    tick(70000);
    n_fail++;
    finish_test();
  end
endmodule
